// [hdl/vclamp_consts.svh]
// Constants of the video clamp timing block: offsets, field positions,
// reset values and clamp codes. Assumes inclusion by bare name.
`ifndef VCLAMP_CONSTS_SVH
`define VCLAMP_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VCLAMP_OFS_START_DELAY 8'h05
`define VCLAMP_OFS_WIDTH_COUNT 8'h06
`define VCLAMP_OFS_BANDWIDTH 8'h0E
`define VCLAMP_OFS_CLAMP_CTRL 8'h0F
`define VCLAMP_OFS_MID_SELECT 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VCLAMP_BIT_EXT_SELECT 7
`define VCLAMP_BIT_POLARITY 6
`define VCLAMP_BIT_RED_MID 1
`define VCLAMP_BIT_BLUE_MID 2
`define VCLAMP_BW_LSB 0
`define VCLAMP_BW_MSB 1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define VCLAMP_RST_START_DELAY 8'h08
`define VCLAMP_RST_WIDTH_COUNT 8'h14
`define VCLAMP_RST_BYTE 8'h00
`define VCLAMP_CODE_GROUND 8'h00
`define VCLAMP_CODE_MIDSCALE 8'h80

`endif

// [hdl/vclamp_pkg.sv]
// Types of the video clamp timing block.
// Assumes nothing beyond a SystemVerilog compiler.
package vclamp_pkg;

  // Register write request as delivered by the serial port decoder
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vclamp_req_s;

  // Analog bandwidth choices
  typedef enum logic [1:0] {
    VCLAMP_BW_75 = 2'h0,
    VCLAMP_BW_150 = 2'h1,
    VCLAMP_BW_300 = 2'h2,
    VCLAMP_BW_500 = 2'h3
  } vclamp_bw_e;

  // Generator states, Gray along idle, delay, clamp
  typedef enum logic [1:0] {
    VCLAMP_IDLE = 2'b00,
    VCLAMP_DELAY = 2'b01,
    VCLAMP_CLAMP = 2'b11
  } vclamp_state_e;

endpackage

// [hdl/vclamp_gen.sv]
// Internal clamp timing generator: start delay then width, per line.
// Assumes hsync is active high and synchronous to the pixel clock.
module vclamp_gen
  import vclamp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsync,
  input wire logic [7:0] start_delay,
  input wire logic [7:0] width_count,
  output logic in_clamp
);

  logic hsync_q;
  logic [7:0] cnt;
  logic [8:0] since_edge;
  logic [8:0] clamp_len;
  vclamp_state_e state;
  wire trail_edge = hsync_q & ~hsync;
  wire cnt_done = (cnt == 8'h00);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Any trailing edge restarts, so a short line never leaves a stale clamp
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hsync_q <= 1'b0;
      state <= VCLAMP_IDLE;
      cnt <= 8'h00;
    end else begin
      hsync_q <= hsync;
      if (trail_edge) begin
        state <= VCLAMP_DELAY;
        cnt <= start_delay;
      end else begin
        unique case (state)
          VCLAMP_IDLE: begin
            cnt <= 8'h00;
          end
          VCLAMP_DELAY: begin
            if (cnt_done) begin
              state <= (width_count == 8'h00) ? VCLAMP_IDLE : VCLAMP_CLAMP;
              cnt <= width_count - 8'h01;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          VCLAMP_CLAMP: begin
            if (cnt_done) begin
              state <= VCLAMP_IDLE;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          default: begin
            state <= VCLAMP_IDLE;
          end
        endcase
      end
    end
  end

  assign in_clamp = (state == VCLAMP_CLAMP);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper counters for the timing checks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_edge <= 9'h1FF;
      clamp_len <= 9'h000;
    end else begin
      since_edge <= trail_edge ? 9'h000 : (since_edge == 9'h1FF ? since_edge : since_edge + 9'h001);
      clamp_len <= in_clamp ? clamp_len + 9'h001 : 9'h000;
    end
  end

  a_start_delay_time: assert property (
    @(posedge clk) disable iff (reset)
    $rose(in_clamp) && $stable(start_delay) |-> since_edge == {1'b0, start_delay} + 9'h001)
    else $error("clamp start not at programmed delay");

  a_width_count_len: assert property (
    @(posedge clk) disable iff (reset)
    $fell(in_clamp) && !$past(trail_edge) && $stable(width_count)
      |-> clamp_len == {1'b0, width_count})
    else $error("clamp width differs from programmed count");

  a_idle_stays_low: assert property (
    @(posedge clk) disable iff (reset)
    state == VCLAMP_IDLE && !trail_edge |=> !in_clamp [*2])
    else $error("clamp rose without a trailing hsync edge");

endmodule

// [hdl/vclamp_top.sv]
// Clamp timing and clamp reference control of a triple video digitizer.
// Assumes a pixel clock on CLK, register writes already decoded from the
// serial port, and hsync already sliced to an active-high level.
`include "vclamp_consts.svh"

module vclamp_top
  import vclamp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSYNC,
  input wire logic CLAMP_PIN,
  input wire vclamp_pkg::vclamp_req_s REG_REQ,
  input wire logic [7:0] REG_RADDR,
  output logic [7:0] REG_RDATA,
  output logic CLAMP,
  output logic [7:0] RED_CLAMP_CODE,
  output logic [7:0] GREEN_CLAMP_CODE,
  output logic [7:0] BLUE_CLAMP_CODE,
  output logic RED_MID_REFERENCE,
  output logic BLUE_MID_REFERENCE,
  output vclamp_pkg::vclamp_bw_e BANDWIDTH_SEL
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] clamp_start_delay;
  logic [7:0] clamp_width_count;
  logic [7:0] bandwidth_reg;
  logic [7:0] clamp_ctrl;
  logic [7:0] mid_select;
  logic gen_clamp;

  // Address match shared by write and read decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Write decode
  wire wr_start = REG_REQ.we && hit(REG_REQ.addr, `VCLAMP_OFS_START_DELAY);
  wire wr_width = REG_REQ.we && hit(REG_REQ.addr, `VCLAMP_OFS_WIDTH_COUNT);
  wire wr_bw = REG_REQ.we && hit(REG_REQ.addr, `VCLAMP_OFS_BANDWIDTH);
  wire wr_ctrl = REG_REQ.we && hit(REG_REQ.addr, `VCLAMP_OFS_CLAMP_CTRL);
  wire wr_mid = REG_REQ.we && hit(REG_REQ.addr, `VCLAMP_OFS_MID_SELECT);

  // Register writes; resets favour the usual starting clamp placement
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      clamp_start_delay <= `VCLAMP_RST_START_DELAY;
      clamp_width_count <= `VCLAMP_RST_WIDTH_COUNT;
      bandwidth_reg <= `VCLAMP_RST_BYTE;
      clamp_ctrl <= `VCLAMP_RST_BYTE;
      mid_select <= `VCLAMP_RST_BYTE;
    end else begin
      if (wr_start) clamp_start_delay <= REG_REQ.wdata;
      if (wr_width) clamp_width_count <= REG_REQ.wdata;
      if (wr_bw) bandwidth_reg <= REG_REQ.wdata;
      if (wr_ctrl) clamp_ctrl <= REG_REQ.wdata;
      if (wr_mid) mid_select <= REG_REQ.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  // Selects and levels pulled out of the control bytes
  wire ext_select = clamp_ctrl[`VCLAMP_BIT_EXT_SELECT];
  wire pin_active_low = clamp_ctrl[`VCLAMP_BIT_POLARITY];
  wire red_mid = mid_select[`VCLAMP_BIT_RED_MID];
  wire blue_mid = mid_select[`VCLAMP_BIT_BLUE_MID];
  wire pin_clamp = CLAMP_PIN ^ pin_active_low;
  // Without hsync the generator stays idle, so only the pin, with ext_select set, can raise CLAMP
  wire next_clamp = ext_select ? pin_clamp : gen_clamp;
  wire [7:0] next_red_code = red_mid ? `VCLAMP_CODE_MIDSCALE : `VCLAMP_CODE_GROUND;
  wire [7:0] next_blue_code = blue_mid ? `VCLAMP_CODE_MIDSCALE : `VCLAMP_CODE_GROUND;
  wire vclamp_bw_e next_bw = vclamp_bw_e'(bandwidth_reg[`VCLAMP_BW_MSB:`VCLAMP_BW_LSB]);

  // Read multiplexer; unmapped offsets read zero
  wire [7:0] next_rdata =
    hit(REG_RADDR, `VCLAMP_OFS_START_DELAY) ? clamp_start_delay :
    hit(REG_RADDR, `VCLAMP_OFS_WIDTH_COUNT) ? clamp_width_count :
    hit(REG_RADDR, `VCLAMP_OFS_BANDWIDTH) ? {6'h00, bandwidth_reg[1:0]} :
    hit(REG_RADDR, `VCLAMP_OFS_CLAMP_CTRL) ? {clamp_ctrl[7:6], 5'h00, gen_clamp} :
    hit(REG_RADDR, `VCLAMP_OFS_MID_SELECT) ? {5'h00, mid_select[2:1], 1'b0} :
    8'h00;

  // ----------------------------------------------------------------
  // Internal generator
  // ----------------------------------------------------------------
  vclamp_gen u_gen (
    .clk(CLK),
    .reset(RESET),
    .hsync(HSYNC),
    .start_delay(clamp_start_delay),
    .width_count(clamp_width_count),
    .in_clamp(gen_clamp)
  );

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // One flop stage on every output keeps pin timing independent of decode
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
      CLAMP <= 1'b0;
      RED_CLAMP_CODE <= `VCLAMP_CODE_GROUND;
      GREEN_CLAMP_CODE <= `VCLAMP_CODE_GROUND;
      BLUE_CLAMP_CODE <= `VCLAMP_CODE_GROUND;
      RED_MID_REFERENCE <= 1'b0;
      BLUE_MID_REFERENCE <= 1'b0;
      BANDWIDTH_SEL <= VCLAMP_BW_75;
    end else begin
      REG_RDATA <= next_rdata;
      CLAMP <= next_clamp;
      RED_CLAMP_CODE <= next_red_code;
      GREEN_CLAMP_CODE <= `VCLAMP_CODE_GROUND;
      BLUE_CLAMP_CODE <= next_blue_code;
      RED_MID_REFERENCE <= red_mid;
      BLUE_MID_REFERENCE <= blue_mid;
      BANDWIDTH_SEL <= next_bw;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ext_pin_pass: assert property (
    @(posedge CLK) disable iff (RESET)
    ext_select && !wr_ctrl ##1 1'b1 |-> CLAMP == ($past(CLAMP_PIN) ^ $past(pin_active_low)))
    else $error("external clamp not passed from pin");

  a_pin_polarity_sel: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_ctrl && REG_REQ.wdata[`VCLAMP_BIT_POLARITY] && REG_REQ.wdata[`VCLAMP_BIT_EXT_SELECT]
      ##1 !wr_ctrl && CLAMP_PIN == 1'b0 |=> CLAMP)
    else $error("active-low pin level did not clamp");

  a_internal_gen_used: assert property (
    @(posedge CLK) disable iff (RESET)
    !ext_select |=> CLAMP == $past(gen_clamp))
    else $error("internal clamp not routed");

  a_width_reg_write: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_width |=> clamp_width_count == $past(REG_REQ.wdata))
    else $error("width register did not take write");

  a_ground_code_out: assert property (
    @(posedge CLK) disable iff (RESET)
    !red_mid && !wr_mid |=> RED_CLAMP_CODE == 8'h00 && GREEN_CLAMP_CODE == 8'h00)
    else $error("ground clamp code not 00H");

  a_mid_code_out: assert property (
    @(posedge CLK) disable iff (RESET)
    blue_mid && !wr_mid |=> BLUE_CLAMP_CODE == 8'h80 && BLUE_MID_REFERENCE)
    else $error("midscale clamp code not 80H");

  a_mid_select_bits: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_mid |-> ##2 RED_MID_REFERENCE == $past(REG_REQ.wdata[1], 2)
      && BLUE_MID_REFERENCE == $past(REG_REQ.wdata[2], 2))
    else $error("midscale select bits misplaced");

  a_bandwidth_follow: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_bw |-> ##2 BANDWIDTH_SEL == vclamp_bw_e'($past(REG_REQ.wdata[1:0], 2)))
    else $error("bandwidth select not applied");

  // ----------------------------------------------------------------
  // Register and output checks
  // ----------------------------------------------------------------
  // Outputs lag decode by one flop, so every check looks one edge on
  a_delay_reg_write: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_start |=> clamp_start_delay == $past(REG_REQ.wdata))
    else $error("start delay register did not take write");

  a_pin_high_level: assert property (
    @(posedge CLK) disable iff (RESET)
    ext_select && !pin_active_low |=> CLAMP == $past(CLAMP_PIN))
    else $error("active-high pin level not followed");

  a_pin_low_level: assert property (
    @(posedge CLK) disable iff (RESET)
    ext_select && pin_active_low |=> CLAMP == !$past(CLAMP_PIN))
    else $error("active-low pin level not inverted");

  a_red_mid_code: assert property (
    @(posedge CLK) disable iff (RESET)
    red_mid |=> RED_CLAMP_CODE == 8'h80 && RED_MID_REFERENCE)
    else $error("red midscale code not 80H");

  a_blue_ground_code: assert property (
    @(posedge CLK) disable iff (RESET)
    !blue_mid |=> BLUE_CLAMP_CODE == 8'h00 && !BLUE_MID_REFERENCE)
    else $error("blue ground code not 00H");

  a_delay_read_back: assert property (
    @(posedge CLK) disable iff (RESET)
    REG_RADDR == `VCLAMP_OFS_START_DELAY |=> REG_RDATA == $past(clamp_start_delay))
    else $error("start delay read back wrong");

  a_width_read_back: assert property (
    @(posedge CLK) disable iff (RESET)
    REG_RADDR == `VCLAMP_OFS_WIDTH_COUNT |=> REG_RDATA == $past(clamp_width_count))
    else $error("width count read back wrong");

  a_live_clamp_read: assert property (
    @(posedge CLK) disable iff (RESET)
    REG_RADDR == `VCLAMP_OFS_CLAMP_CTRL |=> REG_RDATA[0] == $past(gen_clamp))
    else $error("live clamp state read back wrong");

endmodule

// [verification/vclamp_src.sv]
// Model of the graphics source: sends one horizontal sync pulse on request.
// Assumes the bench pulses go for one cycle while sync is low.
module vclamp_src (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [7:0] sync_len,
  output logic hsync
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Sync pulse of sync_len cycles, low between lines
  // ----------------------------------------------------------------
  logic [7:0] cnt;

  // Sync stays low when idle, so sync-less runs rely on the clamp pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 8'h00;
      hsync <= 1'b0;
    end else if (go && !hsync) begin
      cnt <= sync_len;
      hsync <= 1'b1;
    end else if (hsync) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        hsync <= 1'b0; // Trailing edge
      end
    end
  end
endmodule

// [verification/tb.sv]
// Self-checking bench of the clamp timing block with a sync source model.
// Assumes a 100 MHz pixel clock and decoded register writes.
module tb;
  import vclamp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals, instances, clock and timeout
  // ----------------------------------------------------------------
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} vclamp_row_s;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic CLAMP_PIN = 1'b0;
  logic go = 1'b0;
  logic HSYNC;
  vclamp_req_s REG_REQ = '0;
  logic [7:0] REG_RADDR = 8'h00;
  logic [7:0] REG_RDATA, RED_CLAMP_CODE, GREEN_CLAMP_CODE, BLUE_CLAMP_CODE;
  logic CLAMP, RED_MID_REFERENCE, BLUE_MID_REFERENCE;
  vclamp_bw_e BANDWIDTH_SEL;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // Last row writes an unmapped place, which must read back as zero
  vclamp_row_s rows[6] = '{'{8'h05, 8'hA5, 8'hA5}, '{8'h06, 8'h5A, 8'h5A},
    '{8'h0E, 8'hFF, 8'h03}, '{8'h0F, 8'hFF, 8'hC0}, '{8'h10, 8'hFF, 8'h06},
    '{8'h33, 8'hFF, 8'h00}};

  vclamp_top i_vclamp_top (.CLK(CLK), .RESET(RESET), .HSYNC(HSYNC), .CLAMP_PIN(CLAMP_PIN),
    .REG_REQ(REG_REQ), .REG_RADDR(REG_RADDR), .REG_RDATA(REG_RDATA), .CLAMP(CLAMP),
    .RED_CLAMP_CODE(RED_CLAMP_CODE), .GREEN_CLAMP_CODE(GREEN_CLAMP_CODE),
    .BLUE_CLAMP_CODE(BLUE_CLAMP_CODE), .RED_MID_REFERENCE(RED_MID_REFERENCE),
    .BLUE_MID_REFERENCE(BLUE_MID_REFERENCE), .BANDWIDTH_SEL(BANDWIDTH_SEL));
  vclamp_src i_vclamp_src (.clk(CLK), .reset(RESET), .go(go), .sync_len(8'h04),
    .hsync(HSYNC));

  initial begin
    forever #5 CLK = ~CLK;
  end

  // Longest line check is about 270 cycles; ceiling leaves wide margin
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) REG_REQ <= '{we: 1'b1, addr: a, wdata: d};
    @(posedge CLK) REG_REQ.we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK) REG_RADDR <= a;
    @(posedge CLK);
    @(negedge CLK) chk("read data", exp, REG_RDATA);
  endtask

  // One sync line; sample j=0 is one edge past the fall, clamp seen at D+2 for W samples
  task automatic line_check(input int d, input int w, input bit ext);
    int k;
    k = 0;
    @(posedge CLK) go <= 1'b1;
    @(posedge CLK) go <= 1'b0;
    while (HSYNC !== 1'b1 && k < 50) begin
      @(negedge CLK) k++;
    end
    while (HSYNC !== 1'b0 && k < 100) begin
      @(negedge CLK) k++;
    end
    for (int j = 0; j < d + w + 6; j++) begin
      @(negedge CLK) chk("clamp", {7'h00, !ext && j >= d + 2 && j < d + 2 + w}, {7'h00, CLAMP});
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    rd(8'h05, 8'h08);
    rd(8'h06, 8'h14);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
    end
    for (int b = 0; b < 4; b++) begin
      wr(8'h0E, 8'(b));
      repeat (2) @(negedge CLK);
      chk("bandwidth", 8'(b), {6'h00, BANDWIDTH_SEL});
    end
    // Every red/blue combination, green must stay at ground
    for (int m = 0; m < 4; m++) begin
      wr(8'h10, 8'(m << 1));
      repeat (2) @(negedge CLK);
      chk("red mid", {7'h00, m[0]}, {7'h00, RED_MID_REFERENCE});
      chk("blue mid", {7'h00, m[1]}, {7'h00, BLUE_MID_REFERENCE});
      chk("red code", m[0] ? 8'h80 : 8'h00, RED_CLAMP_CODE);
      chk("blue code", m[1] ? 8'h80 : 8'h00, BLUE_CLAMP_CODE);
      chk("green code", 8'h00, GREEN_CLAMP_CODE);
    end
    // Internal generator: shortest, recommended, zero width, longest delay
    wr(8'h0F, 8'h00);
    foreach (rows[i]) begin
      if (i < 4) begin
        wr(8'h05, i == 1 ? 8'h08 : (i == 3 ? 8'hFF : 8'(i * 2)));
        wr(8'h06, i == 1 ? 8'h14 : (i == 2 ? 8'h00 : 8'h02));
        line_check(i == 1 ? 8 : (i == 3 ? 255 : i * 2), i == 1 ? 20 : (i == 2 ? 0 : 2), 0);
      end
    end
    // External pin with both polarities
    for (int p = 0; p < 4; p++) begin
      wr(8'h0F, {1'b1, p[1], 6'h00});
      @(posedge CLK) CLAMP_PIN <= p[0];
      repeat (2) @(negedge CLK);
      chk("pin clamp", {7'h00, p[0] ^ p[1]}, {7'h00, CLAMP});
    end
    @(posedge CLK) CLAMP_PIN <= 1'b0;
    wr(8'h0F, 8'h80);
    line_check(2, 3, 1);
    // Second reset in mid-run restores the defaults
    @(posedge CLK) RESET <= 1'b1;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    rd(8'h05, 8'h08);
    rd(8'h06, 8'h14);
    rd(8'h0F, 8'h00);
    final_report();
  end
endmodule
